// ==== src/tip_pwm.sv ====
// three-phase inverter pwm generator with apb register access
`timescale 1ns/1ns
// ----------------------------------------------------------------
// How it works
// RL1 - six outputs: three high/low phase pairs
// RL2 - polarity pin selects active level, off state
// RL3 - segment register disables each output separately
// RL4 - crossover bit swaps high and low of pair
// RL5 - eight-bit field sets chopping frequency
// RL6 - separate chop enables for high, low sides
// RL7 - single mode: update once per period
// RL8 - double mode: also update at midpoint
// RL9 - mode bit 6 selects double update
// RL10 - sync pulse at period start, at midpoint too in double mode
// RL11 - trip pin low forces outputs off instantly
// RL12 - selected io lines act like trip pin
// RL13 - hardware shutdown path bypasses all flops
// RL14 - software shutdown register write stops outputs
// RL15 - status shows trip, polarity, half-period flag
// RL16 - timing step is one clock cycle
// RL17 - interrupts on sync and on shutdown
// RL18 - timing unit outputs active low internally; the code keeps them active high
// RL19 - complementary centered pairs with dead time
// RL20 - shutdown sources combined reset timing unit
// RL21 - period, dead time, pulse deletion registers
// RL22 - one sixteen-bit duty register per phase
// RL23 - period register counts half a period
// RL24 - dead time is twice the value, zero none
// RL25 - sync width is value plus one, reset 0x27
// RL26 - sync rising edge latches config and duties
// ----------------------------------------------------------------
module tip_pwm
	import tip_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        OUTPUT_POLARITY_PIN,
	input  wire logic        TRIP_INPUT_PIN_N,
	input  wire logic [11:0] GENERAL_IO_LINES,
	output logic             PHASE_A_HIGH_OUT,
	output logic             PHASE_A_LOW_OUT,
	output logic             PHASE_B_HIGH_OUT,
	output logic             PHASE_B_LOW_OUT,
	output logic             PHASE_C_HIGH_OUT,
	output logic             PHASE_C_LOW_OUT,
	output logic             PERIOD_SYNC_PULSE,
	output logic             SYNC_IRQ,
	output logic             SHUTDOWN_IRQ
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		tip_cfg_type  live;
		tip_cfg_type  shadow;
		logic [9:0]   gate;
		logic         double_mode;
		logic [11:0]  io_sel;
		logic         shut;
		logic         sd_prev;
		logic [15:0]  cnt;
		logic         half;
		logic [8:0]   sync_cnt;
		logic         sync_out;
		logic [7:0]   chop_cnt;
		logic         chop;
		logic [5:0]   pins;
		logic         pins_pol;
		logic [31:0]  prdata;
		logic         pready;
		logic         pslverr;
		logic         sync_irq;
		logic         shut_irq;
		logic         trip_m;
		logic         trip_s;
		logic         pol_m;
		logic         pol_s;
		logic [11:0]  io_m;
		logic [11:0]  io_s;
	} tip_state_type;

	tip_state_type q;
	tip_state_type d;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// true when a timing-unit signal commands its switch on
	function automatic logic phase_on(
		input logic [15:0] cnt,
		input logic [15:0] duty,
		input logic [15:0] per,
		input logic [9:0]  dead,
		input logic [15:0] pdel,
		input logic        high
	);
		logic signed [19:0] edge_pos;
		logic signed [19:0] dt2;
		logic signed [19:0] c;
		logic signed [19:0] w;
		logic               on;
		edge_pos = $signed({4'h0, per}) - $signed({4'h0, duty});
		dt2      = $signed({9'h000, dead, 1'b0});                   // RL24
		c        = $signed({4'h0, cnt});
		if (high) begin
			on = (c >= edge_pos + dt2);                              // RL19
			w  = $signed({4'h0, duty}) - dt2;
		end else begin
			on = (c < edge_pos - dt2);                               // RL19
			w  = edge_pos - dt2;
		end
		if (w < $signed({4'h0, pdel})) begin
			on = 1'b0;                                               // RL21
		end
		return on;
	endfunction : phase_on

	function automatic logic hit(
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return addr == ofs;
	endfunction : hit

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic       sd;
	logic       period_start;
	logic       midpoint;
	logic       wr;
	logic [5:0] on;
	logic [5:0] routed;

	always_comb begin
		d = q;
		d.sync_irq = 1'b0;
		d.shut_irq = 1'b0;
		period_start = 1'b0;
		midpoint = 1'b0;
		on = 6'h00;
		routed = 6'h00;

		// two-stage pin synchronisers
		d.trip_m = TRIP_INPUT_PIN_N;
		d.trip_s = q.trip_m;
		d.pol_m  = OUTPUT_POLARITY_PIN;
		d.pol_s  = q.pol_m;
		d.io_m   = GENERAL_IO_LINES;
		d.io_s   = q.io_m;

		// apb slave, zero wait states
		wr = PSEL & PENABLE & q.pready & PWRITE;
		d.pready = PSEL & ~PENABLE & ~q.pready;
		if (PSEL & ~PENABLE) begin
			d.pslverr = 1'b0;
			d.prdata = 32'h0000_0000;
			case (PADDR)
				OFS_PERIOD:     d.prdata[15:0] = q.live.period;
				OFS_DEAD_TIME:  d.prdata[9:0]  = q.live.dead;
				OFS_PULSE_DEL:  d.prdata[15:0] = q.live.pdel;
				OFS_SYNC_WIDTH: d.prdata[7:0]  = q.live.swidth;
				OFS_DUTY_A:     d.prdata[15:0] = q.live.duty_a;
				OFS_DUTY_B:     d.prdata[15:0] = q.live.duty_b;
				OFS_DUTY_C:     d.prdata[15:0] = q.live.duty_c;
				OFS_SEGMENT:    d.prdata[8:0]  = q.live.seg;
				OFS_GATE_CHOP:  d.prdata[9:0]  = q.gate;
				OFS_MODE:       d.prdata[MODE_DOUBLE_BIT] = q.double_mode;
				OFS_IO_SEL:     d.prdata[11:0] = q.io_sel;
				OFS_SW_SHUT:    d.prdata = 32'h0000_0000;
				OFS_STATUS: begin
					d.prdata[STAT_TRIP_BIT] = q.trip_s;               // RL15
					d.prdata[STAT_POL_BIT]  = q.pol_s;                // RL15
					d.prdata[STAT_HALF_BIT] = q.half;                 // RL15
					d.prdata[STAT_SHUT_BIT] = q.shut;
				end
				default:        d.pslverr = 1'b1;
			endcase
		end
		if (wr) begin
			if (hit(PADDR, OFS_PERIOD)) begin
				d.live.period = PWDATA[15:0];                        // RL21
			end
			if (hit(PADDR, OFS_DEAD_TIME)) begin
				d.live.dead = PWDATA[9:0];                           // RL21
			end
			if (hit(PADDR, OFS_PULSE_DEL)) begin
				d.live.pdel = PWDATA[15:0];                          // RL21
			end
			if (hit(PADDR, OFS_SYNC_WIDTH)) begin
				d.live.swidth = PWDATA[7:0];
			end
			if (hit(PADDR, OFS_DUTY_A)) begin
				d.live.duty_a = PWDATA[15:0];                        // RL22
			end
			if (hit(PADDR, OFS_DUTY_B)) begin
				d.live.duty_b = PWDATA[15:0];                        // RL22
			end
			if (hit(PADDR, OFS_DUTY_C)) begin
				d.live.duty_c = PWDATA[15:0];                        // RL22
			end
			if (hit(PADDR, OFS_SEGMENT)) begin
				d.live.seg = PWDATA[8:0];
			end
			if (hit(PADDR, OFS_GATE_CHOP)) begin
				d.gate = PWDATA[9:0];
			end
			if (hit(PADDR, OFS_MODE)) begin
				d.double_mode = PWDATA[MODE_DOUBLE_BIT];             // RL9
			end
			if (hit(PADDR, OFS_IO_SEL)) begin
				d.io_sel = PWDATA[11:0];
			end
			// writing 1 to the status shutdown bit re-arms the outputs
			if (hit(PADDR, OFS_STATUS) && PWDATA[STAT_SHUT_BIT]) begin
				d.shut = 1'b0;
			end
		end
		// any shutdown source latches; setting wins over clearing
		if ((wr && hit(PADDR, OFS_SW_SHUT)) || !q.trip_s ||
			(|(q.io_s & q.io_sel))) begin
			d.shut = 1'b1;                                           // RL14
		end

		// shutdown controller resets the timing unit
		sd = q.shut | ~q.trip_s | (|(q.io_s & q.io_sel));            // RL20
		d.sd_prev = sd;
		d.shut_irq = sd & ~q.sd_prev;                                // RL17

		// up/down half-period counter, one step per clock
		if (sd || q.shadow.period == 16'h0000) begin
			d.cnt  = 16'h0000;                                       // RL20
			d.half = 1'b0;
			if (q.shadow.period == 16'h0000 && !sd) begin
				period_start = 1'b1;
			end
		end else if (!q.half) begin
			if (q.cnt == q.shadow.period - 16'h0001) begin
				d.half = 1'b1;                                       // RL23
				midpoint = 1'b1;
			end else begin
				d.cnt = q.cnt + 16'h0001;                            // RL16
			end
		end else begin
			if (q.cnt == 16'h0000) begin
				d.half = 1'b0;                                       // RL23
				period_start = 1'b1;
			end else begin
				d.cnt = q.cnt - 16'h0001;
			end
		end

		// sync pulse and register latching
		if (period_start || (midpoint && q.double_mode)) begin    // RL7 RL8
			d.shadow = q.live;                                       // RL26
			d.sync_cnt = {1'b0, q.live.swidth};                      // RL25
			d.sync_out = 1'b1;                                       // RL10
			d.sync_irq = 1'b1;                                       // RL17
			// an idle period register still takes new settings
			if (q.shadow.period == 16'h0000) begin
				d.sync_out = q.live.period != 16'h0000;
				d.sync_irq = q.live.period != 16'h0000;              // RL17
			end
		end else if (q.sync_cnt != 9'h000) begin
			d.sync_cnt = q.sync_cnt - 9'h001;
		end else begin
			d.sync_out = 1'b0;
		end

		// chopping clock
		if (q.chop_cnt >= q.gate[7:0]) begin
			d.chop_cnt = 8'h00;
			d.chop = ~q.chop;                                        // RL5
		end else begin
			d.chop_cnt = q.chop_cnt + 8'h01;
		end

		// timing unit: index 5..0 = a hi, a lo, b hi, b lo, c hi, c lo
		on[5] = phase_on(q.cnt, q.shadow.duty_a, q.shadow.period,
			q.shadow.dead, q.shadow.pdel, 1'b1);
		on[4] = phase_on(q.cnt, q.shadow.duty_a, q.shadow.period,
			q.shadow.dead, q.shadow.pdel, 1'b0);
		on[3] = phase_on(q.cnt, q.shadow.duty_b, q.shadow.period,
			q.shadow.dead, q.shadow.pdel, 1'b1);
		on[2] = phase_on(q.cnt, q.shadow.duty_b, q.shadow.period,
			q.shadow.dead, q.shadow.pdel, 1'b0);
		on[1] = phase_on(q.cnt, q.shadow.duty_c, q.shadow.period,
			q.shadow.dead, q.shadow.pdel, 1'b1);
		on[0] = phase_on(q.cnt, q.shadow.duty_c, q.shadow.period,
			q.shadow.dead, q.shadow.pdel, 1'b0);
		if (sd || q.shadow.period == 16'h0000) begin
			on = 6'h00;
		end

		// output control: crossover then per-output disable
		for (int p = 0; p < 3; p++) begin
			if (q.shadow.seg[SEG_CROSS_LSB + p]) begin
				routed[2*p+1] = on[2*p];                             // RL4
				routed[2*p]   = on[2*p+1];                           // RL4
			end else begin
				routed[2*p+1] = on[2*p+1];
				routed[2*p]   = on[2*p];
			end
		end
		routed = routed & ~q.shadow.seg[5:0];                        // RL3

		// gate drive: chopping then polarity
		for (int i = 0; i < 6; i++) begin
			if (i % 2 == 1 && q.gate[GATE_HI_EN_BIT]) begin
				routed[i] = routed[i] & q.chop;                      // RL6
			end
			if (i % 2 == 0 && q.gate[GATE_LO_EN_BIT]) begin
				routed[i] = routed[i] & q.chop;                      // RL6
			end
		end
		// timing domain is active high; polarity low inverts it
		d.pins = q.pol_s ? routed : ~routed;                         // RL18 RL2
		d.pins_pol = q.pol_s;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			q <= '0;
			q.live.period <= RST_PERIOD;
			q.live.dead   <= RST_DEAD_TIME;
			q.live.pdel   <= RST_PULSE_DEL;
			q.live.swidth <= RST_SYNC_WIDTH;                         // RL25
			q.live.duty_a <= RST_DUTY;
			q.live.duty_b <= RST_DUTY;
			q.live.duty_c <= RST_DUTY;
			q.live.seg    <= RST_SEGMENT;
			q.shadow.swidth <= RST_SYNC_WIDTH;
			q.gate   <= RST_GATE_CHOP;
			q.io_sel <= RST_IO_SEL;
			q.trip_m <= 1'b1;
			q.trip_s <= 1'b1;
			q.pins   <= 6'h3f;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs; hardware shutdown overrides without any clock
	// ----------------------------------------------------------------
	logic hw_shut;
	logic off_level;

	// pins built for another polarity than the pin shows are held off
	assign hw_shut = ~TRIP_INPUT_PIN_N |
		(|(GENERAL_IO_LINES & q.io_sel)) |                           // RL11 RL12 RL13
		(q.pins_pol ^ OUTPUT_POLARITY_PIN);                          // RL2
	assign off_level = ~OUTPUT_POLARITY_PIN;                         // RL2

	assign PHASE_A_HIGH_OUT  = hw_shut ? off_level : q.pins[5];      // RL1
	assign PHASE_A_LOW_OUT   = hw_shut ? off_level : q.pins[4];
	assign PHASE_B_HIGH_OUT  = hw_shut ? off_level : q.pins[3];
	assign PHASE_B_LOW_OUT   = hw_shut ? off_level : q.pins[2];
	assign PHASE_C_HIGH_OUT  = hw_shut ? off_level : q.pins[1];
	assign PHASE_C_LOW_OUT   = hw_shut ? off_level : q.pins[0];
	assign PERIOD_SYNC_PULSE = q.sync_out;
	assign SYNC_IRQ          = q.sync_irq;
	assign SHUTDOWN_IRQ      = q.shut_irq;
	assign PRDATA            = q.prdata;
	assign PREADY            = q.pready;
	assign PSLVERR           = q.pslverr;

endmodule : tip_pwm

// ==== src/tip_pkg.sv ====
// constants and types of the three-phase inverter pwm block
package tip_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PERIOD     = 8'h00;
	localparam logic [7:0] OFS_DEAD_TIME  = 8'h04;
	localparam logic [7:0] OFS_PULSE_DEL  = 8'h08;
	localparam logic [7:0] OFS_SYNC_WIDTH = 8'h0c;
	localparam logic [7:0] OFS_DUTY_A     = 8'h10;
	localparam logic [7:0] OFS_DUTY_B     = 8'h14;
	localparam logic [7:0] OFS_DUTY_C     = 8'h18;
	localparam logic [7:0] OFS_SEGMENT    = 8'h1c;
	localparam logic [7:0] OFS_GATE_CHOP  = 8'h20;
	localparam logic [7:0] OFS_MODE       = 8'h24;
	localparam logic [7:0] OFS_IO_SEL     = 8'h28;
	localparam logic [7:0] OFS_SW_SHUT    = 8'h2c;
	localparam logic [7:0] OFS_STATUS     = 8'h30;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MODE_DOUBLE_BIT  = 6;
	localparam int GATE_HI_EN_BIT   = 8;
	localparam int GATE_LO_EN_BIT   = 9;
	localparam int SEG_CROSS_LSB    = 6;
	localparam int STAT_TRIP_BIT    = 0;
	localparam int STAT_POL_BIT     = 1;
	localparam int STAT_HALF_BIT    = 3;
	localparam int STAT_SHUT_BIT    = 4;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_PERIOD     = 16'h0000;
	localparam logic [9:0]  RST_DEAD_TIME  = 10'h000;
	localparam logic [15:0] RST_PULSE_DEL  = 16'h0000;
	localparam logic [7:0]  RST_SYNC_WIDTH = 8'h27;
	localparam logic [15:0] RST_DUTY       = 16'h0000;
	localparam logic [8:0]  RST_SEGMENT    = 9'h000;
	localparam logic [9:0]  RST_GATE_CHOP  = 10'h000;
	localparam logic [11:0] RST_IO_SEL     = 12'h000;

	// ----------------------------------------------------------------
	// timing configuration latched at each sync pulse
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] period;
		logic [9:0]  dead;
		logic [15:0] pdel;
		logic [7:0]  swidth;
		logic [15:0] duty_a;
		logic [15:0] duty_b;
		logic [15:0] duty_c;
		logic [8:0]  seg;
	} tip_cfg_type;

endpackage : tip_pkg

// ==== test/tip_gate_drv.sv ====
// gate driver model: decodes the six drive pins into switch states
`timescale 1ns/1ns
module tip_gate_drv
	import tip_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       pol,
	input  wire logic [5:0] drv,
	output logic      [5:0] gate_on,
	output int              shoot_cnt
);
	// a switch conducts while its pin sits at the active level
	int shoots = 0;
	assign gate_on = pol ? drv : ~drv;
	assign shoot_cnt = shoots;
	// both switches of one leg on at once would short the dc link
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			if (gate_on[2*i+1] && gate_on[2*i]) begin
				shoots <= shoots + 1;
			end
		end
	end
endmodule : tip_gate_drv

// ==== test/tip_pwm_assertions.sv ====
// concurrent checks on the ports of the pwm block
`timescale 1ns/1ns
module tip_pwm_assertions
	import tip_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        SRST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        OUTPUT_POLARITY_PIN,
	input wire logic        TRIP_INPUT_PIN_N,
	input wire logic        PHASE_A_HIGH_OUT,
	input wire logic        PHASE_A_LOW_OUT,
	input wire logic        PHASE_B_HIGH_OUT,
	input wire logic        PHASE_B_LOW_OUT,
	input wire logic        PHASE_C_HIGH_OUT,
	input wire logic        PHASE_C_LOW_OUT,
	input wire logic        PERIOD_SYNC_PULSE,
	input wire logic        SYNC_IRQ,
	input wire logic        SHUTDOWN_IRQ
);
	logic [5:0] drv;
	logic [5:0] onv;
	assign drv = {PHASE_A_HIGH_OUT, PHASE_A_LOW_OUT, PHASE_B_HIGH_OUT,
		PHASE_B_LOW_OUT, PHASE_C_HIGH_OUT, PHASE_C_LOW_OUT};
	assign onv = OUTPUT_POLARITY_PIN ? drv : ~drv;
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_done;
		PSEL && PENABLE && PREADY;
	endsequence
	sequence s_pol_steady;
		$stable(OUTPUT_POLARITY_PIN) [*8];
	endsequence
	AST_APB_READY: assert property (s_setup |=> PREADY && PENABLE)
		else $error("no ready in the access cycle");
	AST_APB_UNMAPPED: assert property ((s_done ##0 (PADDR > OFS_STATUS))
		|-> PSLVERR && PRDATA == 32'h0) else $error("unmapped not refused");
	AST_SW_READ_ZERO: assert property ((s_done ##0 (!PWRITE &&
		PADDR == OFS_SW_SHUT)) |-> PRDATA == 32'h0) else $error("nonzero read");
	AST_TRIP_OFF: assert property (!TRIP_INPUT_PIN_N |->
		drv == {6{~OUTPUT_POLARITY_PIN}}) else $error("trip did not force off");
	AST_SYNC_IRQ: assert property (SYNC_IRQ |-> PERIOD_SYNC_PULSE)
		else $error("sync interrupt without sync pulse");
	AST_SYNC_START: assert property ($rose(PERIOD_SYNC_PULSE) |-> SYNC_IRQ)
		else $error("sync pulse without interrupt");
	AST_SHUT_PULSE: assert property (SHUTDOWN_IRQ |=> !SHUTDOWN_IRQ)
		else $error("shutdown interrupt longer than one cycle");
	AST_SHUT_OFF: assert property (SHUTDOWN_IRQ |-> ##[0:3] onv == 6'h00)
		else $error("outputs on after shutdown");
	AST_LEG_EXCL: assert property (s_pol_steady |->
		(onv & (onv >> 1) & 6'h15) == 6'h00) else $error("both switches on");
endmodule : tip_pwm_assertions

// ==== test/test_tip_pwm.sv ====
// self-checking bench of the three-phase pwm block
`timescale 1ns/1ns
module test_tip_pwm
	import tip_pkg::*;
;
	logic        clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0;
	logic        pol = 1, trip_n = 1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic [11:0] gio = 12'h000;
	logic        rdy, serr, ah, al, bh, bl, ch, cl, sync, sirq, dirq;
	logic [5:0]  on;
	int          shoot, err_count = 0, checks_done = 0;

	initial forever #50 clk = ~clk;

	tip_pwm tip_pwm_inst (.REF_CLK(clk), .SRST(srst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(addr), .PWDATA(wdat),
		.PRDATA(rdat), .PREADY(rdy), .PSLVERR(serr),
		.OUTPUT_POLARITY_PIN(pol), .TRIP_INPUT_PIN_N(trip_n),
		.GENERAL_IO_LINES(gio), .PHASE_A_HIGH_OUT(ah),
		.PHASE_A_LOW_OUT(al), .PHASE_B_HIGH_OUT(bh), .PHASE_B_LOW_OUT(bl),
		.PHASE_C_HIGH_OUT(ch), .PHASE_C_LOW_OUT(cl),
		.PERIOD_SYNC_PULSE(sync), .SYNC_IRQ(sirq), .SHUTDOWN_IRQ(dirq));
	tip_gate_drv tip_gate_drv_inst (.clk(clk), .pol(pol),
		.drv({ah, al, bh, bl, ch, cl}), .gate_on(on), .shoot_cnt(shoot));

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_hi(ref logic s);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (s !== 1'b1 && k < 200);
		if (s !== 1'b1) begin
			err_count++;
			$display("timeout at %0t", $time);
			stop_test();
		end
	endtask : wait_hi

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwr <= wr;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'b1;
		wait_hi(rdy);
		q = rdat;
		e = serr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m = 32'hffffffff);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q & m, x);
		chk(32'(e), 32'(a > OFS_STATUS));
	endtask : rd

	// counts switch-on cycles of one phase (2 a, 1 b, 0 c) over 16 cycles
	task automatic meas(input int xh, input int xl, input int xi,
		input int xs, input int ph = 2);
		logic [31:0] nh, nl, ni, ns;
		nh = 0;
		nl = 0;
		ni = 0;
		ns = 0;
		wait_hi(sirq);
		wait_hi(sirq);
		repeat (16) begin
			nh += on[2*ph+1];
			nl += on[2*ph];
			ni += sirq;
			ns += sync;
			@(posedge clk);
		end
		chk(32'(nh), 32'(xh));
		chk(32'(nl), 32'(xl));
		chk(32'(ni), 32'(xi));
		chk(32'(ns), 32'(xs));
		$display("pwm test done at %0t", $time);
	endtask : meas

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk(32'(on), 32'h0);
		rd(OFS_SYNC_WIDTH, 32'h27);
		rd(OFS_STATUS, 32'h3);
		rd(8'h40, 32'h0);
		rd(OFS_SW_SHUT, 32'h0);
		wr(OFS_DEAD_TIME, 32'hffffffff);
		rd(OFS_DEAD_TIME, 32'h3ff);
		wr(OFS_SYNC_WIDTH, 32'h2);
		wr(OFS_DUTY_A, 32'h2);
		wr(OFS_DEAD_TIME, 32'h0);
		wr(OFS_PERIOD, 32'h8);
		meas(4, 12, 1, 3);
		wr(OFS_SEGMENT, 32'h100);
		meas(12, 4, 1, 3);
		wr(OFS_SEGMENT, 32'h20);
		meas(0, 12, 1, 3);
		wr(OFS_SEGMENT, 32'h0);
		wr(OFS_DUTY_A, 32'h4);
		wr(OFS_DEAD_TIME, 32'h1);
		meas(4, 4, 1, 3);
		wr(OFS_DUTY_B, 32'h5);
		wr(OFS_DUTY_C, 32'h3);
		meas(6, 2, 1, 3, 1);
		meas(2, 6, 1, 3, 0);
		wr(OFS_GATE_CHOP, 32'h101);
		meas(2, 4, 1, 3);
		wr(OFS_GATE_CHOP, 32'h201);
		meas(4, 2, 1, 3);
		wr(OFS_GATE_CHOP, 32'h0);
		wr(OFS_PULSE_DEL, 32'h3);
		meas(0, 0, 1, 3);
		wr(OFS_PULSE_DEL, 32'h2);
		meas(4, 4, 1, 3);
		wr(OFS_MODE, 32'h40);
		meas(4, 4, 2, 6);
		wr(OFS_MODE, 32'h0);
		trip_n <= 1'b0;
		@(negedge clk);
		chk(32'(on), 32'h0);
		wait_hi(dirq);
		rd(OFS_STATUS, 32'h12, 32'h13);
		trip_n <= 1'b1;
		repeat (4) @(posedge clk);
		wr(OFS_STATUS, 32'h10);
		wr(OFS_IO_SEL, 32'h8);
		gio <= 12'h004;
		repeat (4) @(posedge clk);
		rd(OFS_STATUS, 32'h3, 32'h13);
		gio <= 12'h00c;
		@(negedge clk);
		chk(32'(on), 32'h0);
		wait_hi(dirq);
		gio <= 12'h000;
		repeat (4) @(posedge clk);
		wr(OFS_STATUS, 32'h10);
		wr(OFS_SW_SHUT, 32'h1);
		rd(OFS_STATUS, 32'h10, 32'h10);
		chk(32'(on), 32'h0);
		wr(OFS_STATUS, 32'h10);
		meas(4, 4, 1, 3);
		chk(32'(shoot), 32'h0);
		pol <= 1'b0;
		meas(4, 4, 1, 3);
		trip_n <= 1'b0;
		@(negedge clk);
		chk(32'({ah, al, bh, bl, ch, cl}), 32'h3f);
		stop_test();
	end
endmodule : test_tip_pwm

bind tip_pwm tip_pwm_assertions tip_pwm_assertions_inst (
	.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .OUTPUT_POLARITY_PIN(OUTPUT_POLARITY_PIN),
	.TRIP_INPUT_PIN_N(TRIP_INPUT_PIN_N),
	.PHASE_A_HIGH_OUT(PHASE_A_HIGH_OUT), .PHASE_A_LOW_OUT(PHASE_A_LOW_OUT),
	.PHASE_B_HIGH_OUT(PHASE_B_HIGH_OUT), .PHASE_B_LOW_OUT(PHASE_B_LOW_OUT),
	.PHASE_C_HIGH_OUT(PHASE_C_HIGH_OUT), .PHASE_C_LOW_OUT(PHASE_C_LOW_OUT),
	.PERIOD_SYNC_PULSE(PERIOD_SYNC_PULSE), .SYNC_IRQ(SYNC_IRQ),
	.SHUTDOWN_IRQ(SHUTDOWN_IRQ));
